//--- design/tcb_defs.vh
// Constants for the timing and clock generation block
`ifndef TCB_DEFS_VH
`define TCB_DEFS_VH

// ==================================================
// Register addresses and reset values
`define TCB_ADDR_POWER_CLOCK_CONFIG 8'h99
`define TCB_ADDR_CLOCK_CONTROL 8'h9A
`define TCB_ADDR_ANALOG_SYSTEM_MODE 8'hC5
`define TCB_RST_POWER_CLOCK_CONFIG 8'h00
`define TCB_RST_CLOCK_CONTROL 8'h00
`define TCB_RST_ANALOG_SYSTEM_MODE 8'h00
`define TCB_READ_UNMAPPED 8'h00

// ==================================================
// Field positions
`define TCB_ASM_INDIV_HI 7
`define TCB_ASM_INDIV_LO 6
`define TCB_ASM_PLL_ON 5
`define TCB_ASM_MIC_ON 4
`define TCB_PCC_SYS_OFF 7
`define TCB_PCC_DSP_ON 4
`define TCB_CKC_EMG_MODE 7
`define TCB_CKC_RTC_MODE 6
`define TCB_CKC_DSP_HI 5
`define TCB_CKC_DSP_LO 4
`define TCB_CKC_MCU_HI 3
`define TCB_CKC_MCU_LO 2
`define TCB_CKC_EVT_HI 1
`define TCB_CKC_EVT_LO 0

// ==================================================
// Timing: PLL start-up, dividers off the 24x reference tick
`define TCB_PLL_LOCK_US 40
`define TCB_PLL_LOCK_PERIODS 173
`define TCB_DIV_12X 7'd2
`define TCB_DIV_8X 7'd3
`define TCB_DIV_6X 7'd4
`define TCB_DIV_4X 7'd6
`define TCB_DIV_2X 7'd12
`define TCB_DIV_THIRD 7'd72
`define TCB_DIV_CODEC_PHASE 7'd6
`define TCB_DIV_BIT_HALF 7'd9
`define TCB_FRAME_HALF_BITS 9'd384
`define TCB_FREQ_CORR_MOD 5'd25

`endif

//--- design/tcb_div.v
// Programmable tick divider producing one-cycle enable pulses
`timescale 1ns/1ps
module tcb_div #(
  parameter W = 7
) (
  input wire clock,
  input wire rst_n,
  input wire en,
  input wire sync_clr,
  input wire [W-1:0] div,
  output reg tick_q
);
  reg [W-1:0] cnt_q;
  wire last;

  assign last = (cnt_q >= div - {{(W-1){1'b0}}, 1'b1});

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      tick_q <= 1'b0;
    end else if (sync_clr) begin
      cnt_q <= {W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= en & last;
      if (en) begin
        cnt_q <= last ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // tcb_div

//--- design/tcb_timing_clock_block.v
// Clock generation, selection and serial-port timing of the timing clock block
`timescale 1ns/1ps
`include "tcb_defs.vh"
module tcb_timing_clock_block #(
  parameter LOCK_PERIODS = `TCB_PLL_LOCK_PERIODS
) (
  input wire clock,
  input wire rst_n,
  input wire xtal_tick,
  input wire pll_tick,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire gpc_enable,
  input wire gpc_source_sel,
  input wire port_slave_mode,
  input wire ext_bit_clock,
  input wire ext_frame_sync,
  output reg emergency_clock_q,
  output reg mcu_clock_q,
  output reg dsp_clock_q,
  output reg codec_clock_q,
  output reg codec_input_clock_q,
  output reg port_bit_clock_out_q,
  output reg port_frame_sync_out_q,
  output reg codec_frame_strobe_q,
  output reg frame_event_interrupt_q,
  output reg general_purpose_clock_q,
  output reg general_purpose_clock_oe_q,
  output reg pll_on_q,
  output reg pll_ready_q,
  output reg mic_supply_on_q,
  output reg [3:0] codec_analog_en_q,
  output reg [3:0] codec_digital_en_q,
  output reg system_off_q
);
  // ==================================================
  // Registers
  reg [7:0] power_clock_config_q;
  reg [7:0] clock_control_q;
  reg [7:0] analog_system_mode_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_clock_config_q <= `TCB_RST_POWER_CLOCK_CONFIG;
      clock_control_q <= `TCB_RST_CLOCK_CONTROL;
      analog_system_mode_q <= `TCB_RST_ANALOG_SYSTEM_MODE;
      sfr_rdata_q <= 8'h00;
    end else begin
      if (sfr_wr) begin
        case (sfr_addr)
          `TCB_ADDR_POWER_CLOCK_CONFIG: power_clock_config_q <= sfr_wdata;
          `TCB_ADDR_CLOCK_CONTROL: clock_control_q <= sfr_wdata;
          `TCB_ADDR_ANALOG_SYSTEM_MODE: analog_system_mode_q <= sfr_wdata;
          default: ;
        endcase
      end
      if (sfr_rd) begin
        case (sfr_addr)
          `TCB_ADDR_POWER_CLOCK_CONFIG: sfr_rdata_q <= power_clock_config_q;
          `TCB_ADDR_CLOCK_CONTROL: sfr_rdata_q <= clock_control_q;
          `TCB_ADDR_ANALOG_SYSTEM_MODE: sfr_rdata_q <= analog_system_mode_q;
          default: sfr_rdata_q <= `TCB_READ_UNMAPPED;
        endcase
      end
    end
  end

  wire emg_mode = clock_control_q[`TCB_CKC_EMG_MODE];
  wire rtc_mode = clock_control_q[`TCB_CKC_RTC_MODE];
  wire [1:0] dsp_sel = clock_control_q[`TCB_CKC_DSP_HI:`TCB_CKC_DSP_LO];
  wire [1:0] mcu_sel = clock_control_q[`TCB_CKC_MCU_HI:`TCB_CKC_MCU_LO];
  wire [1:0] evt_sel = clock_control_q[`TCB_CKC_EVT_HI:`TCB_CKC_EVT_LO];
  wire [1:0] indiv = analog_system_mode_q[`TCB_ASM_INDIV_HI:`TCB_ASM_INDIV_LO];
  wire pll_on = analog_system_mode_q[`TCB_ASM_PLL_ON];
  wire sys_off = power_clock_config_q[`TCB_PCC_SYS_OFF];
  wire dsp_on = power_clock_config_q[`TCB_PCC_DSP_ON];

  // ==================================================
  // Input divider
  reg [6:0] indiv_ratio;
  always @* begin
    case (indiv)
      2'b01: indiv_ratio = 7'd2;
      2'b10: indiv_ratio = 7'd4;
      default: indiv_ratio = 7'd1;
    endcase
  end

  wire emg_tick;
  tcb_div #(.W(7)) u_indiv (.clock(clock), .rst_n(rst_n), .en(xtal_tick), .sync_clr(1'b0),
    .div(indiv_ratio), .tick_q(emg_tick));

  // ==================================================
  // PLL start-up delay counted in emergency periods
  reg [8:0] lock_cnt_q;
  wire pll_ok = pll_on & pll_ready_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 9'd0;
      pll_ready_q <= 1'b0;
    end else if (!pll_on) begin
      lock_cnt_q <= 9'd0;
      pll_ready_q <= 1'b0;
    end else if (emg_tick && !pll_ready_q) begin
      lock_cnt_q <= lock_cnt_q + 9'd1;
      if (lock_cnt_q == LOCK_PERIODS[8:0] - 9'd1) begin
        pll_ready_q <= 1'b1;
      end
    end
  end

  // ==================================================
  // PLL-derived ticks from the 24x reference
  wire pll_en = pll_tick & pll_on;
  wire clk42, clk28, clk21, clk14, clk7, clk1;
  tcb_div #(.W(7)) u_d12 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_12X), .tick_q(clk42));
  tcb_div #(.W(7)) u_d8 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_8X), .tick_q(clk28));
  tcb_div #(.W(7)) u_d6 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_6X), .tick_q(clk21));
  tcb_div #(.W(7)) u_d4 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_4X), .tick_q(clk14));
  tcb_div #(.W(7)) u_d2 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_2X), .tick_q(clk7));
  tcb_div #(.W(7)) u_d1 (.clock(clock), .rst_n(rst_n), .en(pll_en), .sync_clr(1'b0),
    .div(`TCB_DIV_THIRD), .tick_q(clk1));

  // ==================================================
  // Slave-mode frame sync edge
  reg ext_fs_q;
  reg ext_dck_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_fs_q <= 1'b0;
      ext_dck_q <= 1'b0;
    end else begin
      ext_fs_q <= ext_frame_sync;
      ext_dck_q <= ext_bit_clock;
    end
  end
  wire slave_sync = port_slave_mode & ext_frame_sync & ~ext_fs_q;

  // ==================================================
  // Codec clocks
  wire codec_phase;
  tcb_div #(.W(7)) u_cph (.clock(clock), .rst_n(rst_n), .en(clk21), .sync_clr(slave_sync),
    .div(`TCB_DIV_CODEC_PHASE), .tick_q(codec_phase));

  reg [4:0] corr_cnt_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      corr_cnt_q <= 5'd0;
    end else if (slave_sync) begin
      corr_cnt_q <= 5'd0;
    end else if (emg_tick) begin
      corr_cnt_q <= (corr_cnt_q == `TCB_FREQ_CORR_MOD - 5'd1) ? 5'd0 : corr_cnt_q + 5'd1;
    end
  end
  wire codec_corr = emg_tick & (corr_cnt_q != `TCB_FREQ_CORR_MOD - 5'd1);

  // ==================================================
  // Glitch-free selection: mcu, dsp and codec choices are only taken between pulses; the gpc source is registered every cycle
  // Tick vector: 0 emg, 1 clk1, 2 clk7, 3 clk14, 4 clk21, 5 clk28, 6 clk42, 7 none
  wire [7:0] ticks = {1'b0, clk42, clk28, clk21, clk14, clk7, clk1, emg_tick};

  function [2:0] tcb_mcu_code;
    input e;
    input p;
    input [1:0] s;
    begin
      if (!e || !p) begin
        tcb_mcu_code = 3'd0;
      end else begin
        tcb_mcu_code = {1'b0, s} + 3'd1;
      end
    end
  endfunction

  reg [2:0] mcu_code_d;
  reg [2:0] dsp_code_d;
  reg [1:0] cdc_code_d;
  always @* begin
    mcu_code_d = tcb_mcu_code(emg_mode, pll_ok, mcu_sel);
    if (sys_off || !dsp_on) begin
      dsp_code_d = 3'd7;
    end else if (!emg_mode) begin
      dsp_code_d = 3'd0;
    end else if (!pll_ok) begin
      dsp_code_d = 3'd7;
    end else begin
      case (dsp_sel)
        2'b00: dsp_code_d = 3'd1;
        2'b01: dsp_code_d = 3'd2;
        2'b10: dsp_code_d = 3'd6;
        default: dsp_code_d = 3'd5;
      endcase
    end
    if (!emg_mode || !pll_ok) begin
      cdc_code_d = 2'd0;
    end else if (rtc_mode) begin
      cdc_code_d = 2'd1;
    end else begin
      cdc_code_d = 2'd2;
    end
  end

  wire [3:0] cdc_ticks = {1'b0, codec_phase, codec_corr, emg_tick};
  reg [2:0] mcu_code_q;
  reg [2:0] dsp_code_q;
  reg [1:0] cdc_code_q;
  reg gpc_src_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mcu_code_q <= 3'd0;
      dsp_code_q <= 3'd7;
      cdc_code_q <= 2'd0;
      gpc_src_q <= 1'b0;
    end else begin
      if (ticks == 8'h00) begin
        mcu_code_q <= mcu_code_d;
        dsp_code_q <= dsp_code_d;
      end
      if (cdc_ticks == 4'h0) begin
        cdc_code_q <= cdc_code_d;
      end
      gpc_src_q <= gpc_source_sel;
    end
  end

  // ==================================================
  // Serial-port master timing from the 8x clock
  wire bit_half;
  reg [8:0] half_cnt_q;
  reg bit_lvl_q;
  tcb_div #(.W(7)) u_bit (.clock(clock), .rst_n(rst_n), .en(clk28), .sync_clr(1'b0),
    .div(`TCB_DIV_BIT_HALF), .tick_q(bit_half));
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_q <= 9'd0;
      bit_lvl_q <= 1'b0;
    end else if (bit_half) begin
      bit_lvl_q <= ~bit_lvl_q;
      half_cnt_q <= (half_cnt_q == `TCB_FRAME_HALF_BITS - 9'd1) ? 9'd0 : half_cnt_q + 9'd1;
    end
  end
  wire master_frame = bit_half & (half_cnt_q == `TCB_FRAME_HALF_BITS - 9'd1);
  wire fs1 = port_slave_mode ? slave_sync : master_frame;

  // ==================================================
  // Frame-event interrupt divider
  reg [3:0] evt_cnt_q;
  reg evt_hit;
  always @* begin
    case (evt_sel)
      2'b00: evt_hit = (evt_cnt_q[3:0] == 4'hF);
      2'b01: evt_hit = (evt_cnt_q[2:0] == 3'h7);
      2'b10: evt_hit = (evt_cnt_q[1:0] == 2'h3);
      default: evt_hit = 1'b1;
    endcase
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt_cnt_q <= 4'h0;
    end else if (fs1) begin
      evt_cnt_q <= evt_cnt_q + 4'h1;
    end
  end

  // ==================================================
  // Output stage
  wire gpc_tick = gpc_src_q ? ticks[mcu_code_q] : emg_tick;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      emergency_clock_q <= 1'b0;
      mcu_clock_q <= 1'b0;
      dsp_clock_q <= 1'b0;
      codec_clock_q <= 1'b0;
      codec_input_clock_q <= 1'b0;
      port_bit_clock_out_q <= 1'b0;
      port_frame_sync_out_q <= 1'b0;
      codec_frame_strobe_q <= 1'b0;
      frame_event_interrupt_q <= 1'b0;
      general_purpose_clock_q <= 1'b0;
      general_purpose_clock_oe_q <= 1'b0;
      pll_on_q <= 1'b0;
      mic_supply_on_q <= 1'b0;
      codec_analog_en_q <= 4'h0;
      codec_digital_en_q <= 4'h0;
      system_off_q <= 1'b0;
    end else begin
      emergency_clock_q <= emg_tick & ~sys_off;
      mcu_clock_q <= ticks[mcu_code_q] & ~sys_off;
      dsp_clock_q <= ticks[dsp_code_q];
      codec_clock_q <= cdc_ticks[cdc_code_q] & ~sys_off;
      codec_input_clock_q <= clk14 & pll_ok & ~sys_off;
      port_bit_clock_out_q <= port_slave_mode ? ext_dck_q : bit_lvl_q;
      port_frame_sync_out_q <= port_slave_mode ? ext_fs_q : (half_cnt_q < 9'd2);
      codec_frame_strobe_q <= fs1 & ~sys_off;
      frame_event_interrupt_q <= fs1 & evt_hit & ~sys_off;
      if (gpc_tick) begin
        general_purpose_clock_q <= gpc_enable & ~general_purpose_clock_q;
      end else if (!gpc_enable) begin
        general_purpose_clock_q <= 1'b0;
      end
      general_purpose_clock_oe_q <= gpc_enable;
      pll_on_q <= pll_on;
      mic_supply_on_q <= analog_system_mode_q[`TCB_ASM_MIC_ON];
      codec_analog_en_q <= analog_system_mode_q[3:0];
      codec_digital_en_q <= power_clock_config_q[3:0] & {4{~sys_off}};
      system_off_q <= sys_off;
    end
  end
endmodule // tcb_timing_clock_block

//--- bench/tcb_far_side.sv
// Far-side model: crystal, PLL and serial-port clock sources
`timescale 1ns/1ps
module tcb_far_side (
  input wire logic clock,
  input wire logic rst_n,
  output logic xtal_tick,
  output logic pll_tick,
  output logic ext_bit_clock,
  output logic ext_frame_sync
);
  // ==========
  // Crystal every 48 cycles, PLL at 24x, frame of 128 cycles
  logic [8:0] cnt_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= (cnt_q == 9'h17F) ? 9'h000 : cnt_q + 9'h001;
    end
  end
  assign xtal_tick = (cnt_q % 48) == 0;
  assign pll_tick = cnt_q[0];
  // Port bit clock runs free, frame sync high for one bit period
  assign ext_bit_clock = cnt_q[2];
  assign ext_frame_sync = cnt_q[6:3] == 4'h0;
endmodule // tcb_far_side

//--- bench/tcb_timing_clock_block_properties.sv
// Port checker of the timing clock block
`timescale 1ns/1ps
module tcb_timing_clock_block_properties #(
  parameter LOCK_PERIODS = 173
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire gpc_enable,
  input wire port_slave_mode,
  input wire ext_bit_clock,
  input wire emergency_clock_q,
  input wire mcu_clock_q,
  input wire dsp_clock_q,
  input wire port_bit_clock_out_q,
  input wire general_purpose_clock_q,
  input wire general_purpose_clock_oe_q,
  input wire pll_on_q,
  input wire pll_ready_q,
  input wire [3:0] codec_digital_en_q,
  input wire system_off_q
);
  // ==========
  // Shadow of clock control and tick counter
  logic [7:0] ckc_q;
  logic [8:0] lock_cnt_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ckc_q <= 8'h00;
      lock_cnt_q <= 9'h000;
    end else begin
      if (sfr_wr && sfr_addr == 8'h9A) begin
        ckc_q <= sfr_wdata;
      end
      lock_cnt_q <= !pll_on_q ? 9'h000 : lock_cnt_q + {8'h00, emergency_clock_q};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_gpc_oe_follow: assert property (general_purpose_clock_oe_q == $past(gpc_enable))
    else $error("gpc enable not followed");
  a_gpc_off_low: assert property (!gpc_enable [*2] |=> !general_purpose_clock_q)
    else $error("gpc active while disabled");
  a_pll_off_unready: assert property (!pll_on_q [*2] |-> !pll_ready_q)
    else $error("pll ready while off");
  a_lock_tick_count: assert property ($rose(pll_ready_q) |->
    lock_cnt_q >= LOCK_PERIODS - 1 && lock_cnt_q <= LOCK_PERIODS + 1)
    else $error("pll ready at wrong tick count");
  a_dsp_pulse_single: assert property (dsp_clock_q |=> !dsp_clock_q)
    else $error("dsp pulse too long");
  a_sysoff_digital_off: assert property (system_off_q |-> codec_digital_en_q == 4'h0)
    else $error("digital paths on in system off");
  a_emg_mcu_source: assert property (!ckc_q[7] && !$past(ckc_q[7], 4) && mcu_clock_q |->
    emergency_clock_q)
    else $error("mcu not on emergency clock");
  a_read_unmapped: assert property (sfr_rd && sfr_addr != 8'h99 && sfr_addr != 8'h9A
    && sfr_addr != 8'hC5 |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_read_clock_ctrl: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h9A |=> sfr_rdata_q == ckc_q)
    else $error("clock control readback wrong");
  a_slave_bit_clock: assert property (port_slave_mode && $past(port_slave_mode)
    && $past(port_slave_mode, 2) |-> port_bit_clock_out_q == $past(ext_bit_clock, 2))
    else $error("slave bit clock not passed");
  c_pll_ready: cover property ($rose(pll_ready_q));
  c_gpc_on: cover property (general_purpose_clock_oe_q && general_purpose_clock_q);
  c_slave_clock: cover property (port_slave_mode && port_bit_clock_out_q);
endmodule // tcb_timing_clock_block_properties

bind tcb_timing_clock_block tcb_timing_clock_block_properties #(.LOCK_PERIODS(LOCK_PERIODS)) i_tcb_props (
  .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .gpc_enable(gpc_enable),
  .port_slave_mode(port_slave_mode), .ext_bit_clock(ext_bit_clock), .emergency_clock_q(emergency_clock_q),
  .mcu_clock_q(mcu_clock_q), .dsp_clock_q(dsp_clock_q), .port_bit_clock_out_q(port_bit_clock_out_q),
  .general_purpose_clock_q(general_purpose_clock_q), .general_purpose_clock_oe_q(general_purpose_clock_oe_q),
  .pll_on_q(pll_on_q), .pll_ready_q(pll_ready_q), .codec_digital_en_q(codec_digital_en_q),
  .system_off_q(system_off_q));

//--- bench/tcb_timing_clock_block_bench.sv
// Self-checking testbench of the timing clock block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tcb_timing_clock_block_bench;
  // ==========
  // Signals and instances
  localparam int LOCK = 4;
  logic clock, rst_n, sfr_wr, sfr_rd, gpc_enable, gpc_source_sel, port_slave_mode;
  logic xtal_tick, pll_tick, ext_bit_clock, ext_frame_sync, emergency_clock_q, mcu_clock_q, dsp_clock_q;
  logic codec_clock_q, codec_input_clock_q, port_bit_clock_out_q, port_frame_sync_out_q, codec_frame_strobe_q;
  logic frame_event_interrupt_q, general_purpose_clock_q, general_purpose_clock_oe_q, pll_on_q, pll_ready_q;
  logic mic_supply_on_q, system_off_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
  logic [3:0] codec_analog_en_q, codec_digital_en_q;
  logic [9:0] mon;
  int fail_count, total_checks;
  assign mon = {port_frame_sync_out_q, general_purpose_clock_q, frame_event_interrupt_q, codec_frame_strobe_q,
    port_bit_clock_out_q,
    codec_input_clock_q, codec_clock_q, dsp_clock_q, mcu_clock_q, emergency_clock_q};
  tcb_far_side i_tcb_far_side (.clock(clock), .rst_n(rst_n), .xtal_tick(xtal_tick), .pll_tick(pll_tick),
    .ext_bit_clock(ext_bit_clock), .ext_frame_sync(ext_frame_sync));
  tcb_timing_clock_block #(.LOCK_PERIODS(LOCK)) i_tcb_timing_clock_block (.clock(clock), .rst_n(rst_n),
    .xtal_tick(xtal_tick), .pll_tick(pll_tick), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .gpc_enable(gpc_enable), .gpc_source_sel(gpc_source_sel),
    .port_slave_mode(port_slave_mode), .ext_bit_clock(ext_bit_clock), .ext_frame_sync(ext_frame_sync),
    .emergency_clock_q(emergency_clock_q), .mcu_clock_q(mcu_clock_q), .dsp_clock_q(dsp_clock_q),
    .codec_clock_q(codec_clock_q), .codec_input_clock_q(codec_input_clock_q),
    .port_bit_clock_out_q(port_bit_clock_out_q), .port_frame_sync_out_q(port_frame_sync_out_q),
    .codec_frame_strobe_q(codec_frame_strobe_q), .frame_event_interrupt_q(frame_event_interrupt_q),
    .general_purpose_clock_q(general_purpose_clock_q), .general_purpose_clock_oe_q(general_purpose_clock_oe_q),
    .pll_on_q(pll_on_q), .pll_ready_q(pll_ready_q), .mic_supply_on_q(mic_supply_on_q),
    .codec_analog_en_q(codec_analog_en_q), .codec_digital_en_q(codec_digital_en_q), .system_off_q(system_off_q));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========
  // Bus and measurement tasks
  task tick;
    @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    `CHK(sfr_rdata_q, e)
    tick;
  endtask
  // Cycles between two rising samples of a monitored output
  task gap(input int k, input int e);
    int n, i, t;
    n = 0;
    t = 0;
    repeat (250) tick;
    for (i = 0; i < 4; i++) begin
      if (i == 2) n = 0;
      while (mon[k] !== i[0] && t < 9000) begin
        tick;
        n++;
        t++;
      end
    end
    if (t >= 9000) begin
      fail_count++;
      report_and_stop;
    end else `CHK(n, e)
  endtask
  // Cycles a monitored output stays high, from a fresh rising sample
  task high_len(input int k, input int e);
    int n, w;
    n = 0;
    w = 0;
    while (mon[k] === 1'b1 && n < 30000) begin
      tick;
      n++;
    end
    while (mon[k] !== 1'b1 && n < 30000) begin
      tick;
      n++;
    end
    while (mon[k] === 1'b1 && w < 30000) begin
      tick;
      w++;
    end
    if (n >= 30000 || w >= 30000) begin
      fail_count++;
      report_and_stop;
    end else `CHK(w, e)
  endtask
  // Pulses of a monitored output within a window of cycles
  task pulses(input int k, input int len, input int e);
    int n;
    n = 0;
    repeat (250) tick;
    repeat (len) begin
      n += int'(mon[k] === 1'b1);
      tick;
    end
    `CHK(n, e)
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  task t_regs;
    rd(8'h99, 8'h00);
    rd(8'h9A, 8'h00);
    rd(8'hC5, 8'h00);
    wr(8'h42, 8'hFF);
    rd(8'h42, 8'h00);
    gap(0, 48);
    pulses(2, 200, 0);
    wr(8'h99, 8'h66);
    wr(8'h9A, 8'h5A);
    wr(8'hC5, 8'h1A);
    rd(8'h99, 8'h66);
    rd(8'h9A, 8'h5A);
    rd(8'hC5, 8'h1A);
    `CHK({mic_supply_on_q, pll_on_q, codec_analog_en_q, codec_digital_en_q}, 10'h2A6)
    wr(8'h99, 8'h86);
    `CHK({system_off_q, codec_digital_en_q}, 5'h10)
    wr(8'h99, 8'h10);
    wr(8'h9A, 8'h0C);
    wr(8'hC5, 8'h40);
    gap(0, 96);
    wr(8'hC5, 8'h80);
    gap(0, 192);
    wr(8'hC5, 8'h00);
    gap(1, 48);
  endtask
  task t_pll;
    int n, i, c;
    int dv[4];
    int mv[4];
    dv = '{72, 12, 2, 3};
    mv = '{72, 12, 6, 4};
    wr(8'hC5, 8'h20);
    n = 0;
    for (i = 0; i < 2000 && pll_ready_q !== 1'b1; i++) begin
      n += int'(emergency_clock_q === 1'b1);
      tick;
    end
    `CHK({pll_ready_q, n >= LOCK - 1 && n <= LOCK + 1}, 2'b11)
    if (pll_ready_q !== 1'b1) report_and_stop;
    for (c = 0; c < 4; c++) begin
      wr(8'h9A, 8'h80 | 8'(c * 20));
      gap(2, 2 * dv[c]);
      gap(1, 2 * mv[c]);
    end
    wr(8'h9A, 8'hB0);
    gap(4, 12);
    gap(3, 48);
    gap(5, 108);
    high_len(9, 108);
    wr(8'h9A, 8'hF0);
    pulses(3, 1200, 24);
  endtask
  task t_slave;
    int c;
    int ev[4];
    ev = '{16, 8, 4, 1};
    port_slave_mode = 1'b1;
    gap(5, 8);
    gap(6, 128);
    high_len(9, 8);
    for (c = 0; c < 4; c++) begin
      wr(8'h9A, 8'hB0 | 8'(c));
      gap(7, 128 * ev[c]);
    end
    port_slave_mode = 1'b0;
  endtask
  task t_gpc;
    gpc_source_sel = 1'b0;
    tick;
    gpc_enable = 1'b1;
    gap(8, 96);
    `CHK(general_purpose_clock_oe_q, 1'b1)
    gpc_enable = 1'b0;
    tick;
    gpc_source_sel = 1'b1;
    tick;
    gpc_enable = 1'b1;
    gap(8, 288);
    gpc_enable = 1'b0;
    repeat (3) tick;
    `CHK({general_purpose_clock_oe_q, general_purpose_clock_q}, 2'b00)
    wr(8'h9A, 8'h00);
    wr(8'hC5, 8'h00);
    tick;
    `CHK(pll_ready_q, 1'b0)
  endtask
  initial begin
    {rst_n, sfr_wr, sfr_rd, gpc_enable, gpc_source_sel, port_slave_mode} = 6'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    t_regs;
    t_pll;
    t_slave;
    t_gpc;
    report_and_stop;
  end
endmodule // tcb_timing_clock_block_bench
